/* File: bench/breaker_model.sv */
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
  // clock
  input wire logic clk_sys,
  // coils and fault switch
  input wire logic open_coil,
  input wire logic close_coil,
  input wire logic stuck,
  // open-side contact, high when open
  output logic aux_open
);
  logic target = 1'b1;
  logic state = 1'b1;
  logic [3:0] delay = 4'h0;
  assign aux_open = state;
  // contact moves some cycles after a coil pulse; stuck mimics a seized drive
  always @(posedge clk_sys) begin
    if (open_coil || close_coil) begin
      target <= open_coil;
      delay <= 4'h6;
    end else if (delay != 4'h0) begin
      delay <= delay - 4'h1;
    end
    if (delay == 4'h1 && !stuck) begin
      state <= target;
    end
  end
endmodule
`default_nettype wire

/* File: bench/swg_supervisor_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module swg_supervisor_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // inputs
  input wire logic aux_open_wired,
  input wire logic [7:0] protection_trip,
  input wire logic [7:0] trip_slot_assigned,
  input wire logic protection_open_block,
  input wire logic [15:0] operations_limit,
  // outputs
  input wire logic switchgear_trip,
  input wire logic open_command,
  input wire logic close_command,
  input wire logic command_busy,
  input wire logic [1:0] breaker_position,
  input wire logic position_overridden,
  input wire logic [15:0] operation_counter,
  input wire logic operations_alarm
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // assigned slots only
  wire logic trip_raw = |(protection_trip & trip_slot_assigned);
  AST_POS_UNWIRED: assert property (!$past(sys_rst) && !$past(aux_open_wired)
    && !aux_open_wired && !position_overridden && !command_busy |-> breaker_position == 2'h3)
    else $error("position not disturbed");
  AST_TRIP_SET: assert property (trip_raw && !protection_open_block
    |=> switchgear_trip || protection_open_block) else $error("trip not set");
  AST_TRIP_CAUSE: assert property ($rose(switchgear_trip) |-> $past(trip_raw))
    else $error("trip without cause");
  AST_TRIP_BLOCK: assert property (protection_open_block ##1 protection_open_block
    |-> !switchgear_trip) else $error("blocked trip");
  AST_TRIP_HOLD: assert property ($fell(switchgear_trip) && !protection_open_block
    && !$past(protection_open_block) |-> !$past(trip_raw) && !$past(trip_raw, 2))
    else $error("trip hold short");
  AST_CMD_PULSE: assert property (open_command || close_command
    |-> command_busy ##1 !open_command && !close_command) else $error("bad pulse");
  AST_BUSY_IGNORE: assert property (command_busy && $past(command_busy)
    |-> !open_command && !close_command) else $error("command while busy");
  AST_ONE_DIR: assert property (!(open_command && close_command))
    else $error("both coils");
  AST_MOVE_INDET: assert property (open_command
    |=> position_overridden || breaker_position == 2'h0) else $error("not indeterminate");
  AST_OPS_ALARM: assert property ($stable(operation_counter)
    |-> operations_alarm == (operation_counter > operations_limit)) else $error("ops alarm");
endmodule
bind switchgear_command_supervisor swg_supervisor_asserts u_swg_supervisor_asserts (.*);
`default_nettype wire

/* File: bench/switchgear_command_supervisor_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module switchgear_command_supervisor_tb import swg_pkg::*;;
  logic clk_sys, sys_rst, aux_open_contact, external_close_request, external_open_request;
  logic trip_acknowledge_input, bypass_signal_input, panel_close_key, panel_open_key;
  logic protection_open_block, auto_reclose_unit, scada_close_cmd, scada_open_cmd;
  logic operator_ack, bypass_arm, stats_clear, aux_open_wired, trip_latch_enable, stuck;
  logic position_override_enable, switchgear_trip, close_command, open_command;
  logic command_busy, command_rejected, position_overridden, interlock_bypass_active;
  logic operations_alarm, current_sum_alarm, hourly_current_sum_alarm, wear_curve_alarm;
  logic slow_operation_alarm;
  logic [1:0] position_override_value, breaker_position;
  logic [2:0] close_interlock, open_interlock, phase_current_alarm;
  logic [3:0] curve_points_used;
  logic [6:0] req;
  logic [7:0] protection_trip, trip_slot_assigned, open_capacity_percent;
  logic [15:0] trip_hold_cycles, operations_limit, operation_counter;
  logic [23:0] interlock_bypass_timeout, move_open_cycles, move_close_cycles;
  logic [31:0] current_sum_threshold, hourly_sum_threshold;
  logic [15:0] curve_current [10], curve_allowed_ops [10], phase_current [3];
  logic [31:0] phase_current_accumulator [3];
  authority_e switching_authority;
  bypass_e interlock_bypass_mode;
  int error_cnt, n_tests, cyc;
  integer nc, no; // four-state, an unknown coil fails
  // command sources driven as one vector
  assign {panel_close_key, panel_open_key, external_close_request, external_open_request,
    scada_close_cmd, scada_open_cmd, auto_reclose_unit} = req;
  switchgear_command_supervisor #(.HOUR_CYCLES(40'h00_0000_2000))
    u_switchgear_command_supervisor (.*);
  breaker_model u_breaker_model (.clk_sys(clk_sys), .open_coil(open_command),
    .close_coil(close_command), .stuck(stuck), .aux_open(aux_open_contact));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, well above the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // raise sources, drop after hold, count coil pulses over a fixed 30 cycle window
  task automatic go(input logic [6:0] src, input int hold, input int ec, input int eo);
    nc = 0;
    no = 0;
    req <= src;
    for (int k = 1; k <= 30; k++) begin
      @(posedge clk_sys);
      if (k == hold) req <= 7'h00;
      nc += close_command;
      no += open_command;
    end
    `CHK(nc, ec)
    `CHK(no, eo)
  endtask
  initial begin
    {sys_rst, req, trip_acknowledge_input, bypass_signal_input, protection_open_block,
      operator_ack, bypass_arm, stats_clear, aux_open_wired, trip_latch_enable, stuck,
      position_override_enable, position_override_value, close_interlock, open_interlock,
      protection_trip} = '0;
    sys_rst = 1'b1;
    trip_slot_assigned = 8'h0F;
    trip_hold_cycles = 16'h0004;
    interlock_bypass_timeout = 24'h000020;
    {move_open_cycles, move_close_cycles} = {24'h00000C, 24'h00000C};
    operations_limit = 16'h0001;
    {current_sum_threshold, hourly_sum_threshold} = {32'h300, 32'h300};
    curve_points_used = 4'h2;
    switching_authority = AUTH_REMOTE;
    interlock_bypass_mode = BYPASS_OFF;
    foreach (curve_current[i]) {curve_current[i], curve_allowed_ops[i]} = {16'h200, 16'h0};
    foreach (phase_current[i]) phase_current[i] = 16'h0100;
    {curve_current[0], curve_allowed_ops[0]} = {16'h0100, 16'h0004};
    tick(5);
    sys_rst <= 1'b0;
    tick(3);
    `CHK(breaker_position, 2'h3)
    aux_open_wired <= 1'b1;
    tick(4);
    `CHK(breaker_position, 2'h1)
    protection_trip <= 8'h20;
    tick(3);
    `CHK(switchgear_trip, 1'b0)
    protection_trip <= 8'h22;
    tick(2);
    `CHK(switchgear_trip, 1'b1)
    protection_trip <= 8'h00;
    tick(3);
    `CHK(switchgear_trip, 1'b1)
    tick(6);
    `CHK(switchgear_trip, 1'b0)
    {trip_latch_enable, protection_trip} <= {1'b1, 8'h01};
    tick(2);
    protection_trip <= 8'h00;
    tick(12);
    `CHK(switchgear_trip, 1'b1)
    operator_ack <= 1'b1;
    tick(1);
    {operator_ack, trip_latch_enable} <= 2'b00;
    tick(3);
    `CHK(switchgear_trip, 1'b0)
    {protection_open_block, protection_trip} <= {1'b1, 8'h01};
    tick(3);
    `CHK(switchgear_trip, 1'b0)
    protection_trip <= 8'h00;
    tick(8);
    protection_open_block <= 1'b0;
    go(7'h04, 1, 1, 0);
    go(7'h04, 1, 0, 0);
    switching_authority <= AUTH_LOCAL;
    go(7'h02, 1, 0, 0);
    go(7'h20, 10, 0, 1);
    go(7'h40, 20, 1, 0);
    switching_authority <= AUTH_NONE;
    go(7'h20, 10, 0, 0);
    {switching_authority, open_interlock} <= {AUTH_LOCAL_REMOTE, 3'h2};
    go(7'h08, 3, 0, 0);
    interlock_bypass_mode <= BYPASS_PERMANENT;
    go(7'h02, 1, 0, 1);
    `CHK(interlock_bypass_active, 1'b1)
    {interlock_bypass_mode, open_interlock, close_interlock} <= {BYPASS_OFF, 3'h0, 3'h1};
    tick(3);
    go(7'h01, 1, 1, 0);
    close_interlock <= 3'h0;
    go(7'h18, 25, 0, 1);
    go(7'h10, 25, 1, 0);
    stuck <= 1'b1;
    go(7'h02, 1, 0, 1);
    `CHK(breaker_position, 2'h3)
    `CHK(slow_operation_alarm, 1'b1)
    tick(100);
    `CHK(open_capacity_percent, 8'h64)
    `CHK(wear_curve_alarm, 1'b1)
    `CHK(operations_alarm, 1'b1)
    `CHK(phase_current_accumulator[2], 32'h400)
    `CHK(phase_current_alarm, 3'h7)
    `CHK(current_sum_alarm, 1'b1)
    `CHK(hourly_current_sum_alarm, 1'b1)
    {position_override_enable, position_override_value} <= {1'b1, 2'h2};
    tick(3);
    `CHK({position_overridden, breaker_position}, 3'h6)
    test_done();
  end
endmodule
`default_nettype wire

/* File: design/edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // asynchronous pins
  input wire logic [WIDTH-1:0] async_in,
  // synchronised level and rising edge
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;

  // meta is only read by stable, never by logic
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end else begin
      meta <= async_in;
      stable <= meta;
      prev <= stable;
    end
  end

  assign level = stable;
  assign rise = stable & ~prev;
endmodule
`default_nettype wire

/* File: design/switchgear_command_supervisor.sv */
// Summary of operation
// - unwired open contact reports position disturbed
// - three interlocks per direction block switching
// - protection open and reclose skip interlocks
// - assigned protection trips ORed into trip
// - only trip manager output trips switchgear
// - trip minimum hold, optional latching
// - latch clears after dropout plus acknowledge
// - one external close, one external open
// - open wins; close edge, open level
// - scada commands need remote authority
// - authority gates panel, external and scada command sources
// - bypass single, permanent, timed, or signal
// - manual position override with marker
// - one command at a time, others ignored
// - suppress command whose target already reached
// - held panel close key gives one pulse
// - count operations, alarm above limit
// - per phase current sums with alarms
// - hourly current sum alarm
// - open capacity percentage, full means maintenance
// - slow alarm when move time exceeded
// - ten point wear curve interpolation
// - position code 0,1,2,3 meanings
// - move timer, indeterminate, disturbed on expiry
`timescale 1ns/1ps
`default_nettype none
`include "swg_defs.svh"
module switchgear_command_supervisor import swg_pkg::*; #(
  parameter logic [39:0] HOUR_CYCLES =
    40'(`SWG_HOUR_S * `SWG_NS_PER_S / `SWG_CLK_PERIOD_NS)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // switchgear pins, asynchronous
  input wire logic aux_open_contact,
  input wire logic [`SWG_NUM_INTERLOCKS-1:0] close_interlock,
  input wire logic [`SWG_NUM_INTERLOCKS-1:0] open_interlock,
  input wire logic external_close_request,
  input wire logic external_open_request,
  input wire logic trip_acknowledge_input,
  input wire logic bypass_signal_input,
  input wire logic panel_close_key,
  input wire logic panel_open_key,
  // internal sources, same clock
  input wire logic [`SWG_TRIP_SLOTS-1:0] protection_trip,
  input wire logic protection_open_block,
  input wire logic auto_reclose_unit,
  input wire logic scada_close_cmd,
  input wire logic scada_open_cmd,
  input wire logic operator_ack,
  input wire logic bypass_arm,
  input wire logic stats_clear,
  // configuration
  input wire logic aux_open_wired,
  input wire logic [`SWG_TRIP_SLOTS-1:0] trip_slot_assigned,
  input wire logic trip_latch_enable,
  input wire logic [15:0] trip_hold_cycles,
  input wire authority_e switching_authority,
  input wire bypass_e interlock_bypass_mode,
  input wire logic [23:0] interlock_bypass_timeout,
  input wire logic position_override_enable,
  input wire logic [1:0] position_override_value,
  input wire logic [23:0] move_open_cycles,
  input wire logic [23:0] move_close_cycles,
  input wire logic [15:0] operations_limit,
  input wire logic [31:0] current_sum_threshold,
  input wire logic [31:0] hourly_sum_threshold,
  input wire logic [3:0] curve_points_used,
  input wire logic [15:0] curve_current [`SWG_CURVE_POINTS],
  input wire logic [15:0] curve_allowed_ops [`SWG_CURVE_POINTS],
  // measured currents at interruption
  input wire logic [15:0] phase_current [`SWG_NUM_PHASES],
  // coil commands and position
  output logic switchgear_trip,
  output logic close_command,
  output logic open_command,
  output logic command_busy,
  output logic command_rejected,
  output logic [1:0] breaker_position,
  output logic position_overridden,
  output logic interlock_bypass_active,
  // wear supervision
  output logic [15:0] operation_counter,
  output logic operations_alarm,
  output logic [31:0] phase_current_accumulator [`SWG_NUM_PHASES],
  output logic [`SWG_NUM_PHASES-1:0] phase_current_alarm,
  output logic current_sum_alarm,
  output logic hourly_current_sum_alarm,
  output logic [7:0] open_capacity_percent,
  output logic wear_curve_alarm,
  output logic slow_operation_alarm
);
  logic [`SWG_SI_WIDTH-1:0] pin_level;
  logic [`SWG_SI_WIDTH-1:0] pin_rise;
  logic [15:0] hold_cnt;
  logic trip_latched;
  logic trip_prev;
  ctl_state_e ctl_state;
  logic target_open;
  logic [23:0] move_cnt;
  logic disturbed;
  logic bypass_run;
  logic [23:0] bypass_cnt;
  logic [39:0] hour_cnt;
  logic [31:0] hour_sum;
  wear_state_e wear_state;
  logic wear_pend;
  logic [15:0] wear_lo_ops;
  logic [31:0] wear_acc;
  logic [31:0] div_q;
  logic [32:0] div_r;
  logic [31:0] div_d;
  logic [5:0] div_cnt;

  // pins cross into the clock domain here
  edge_sync #(.WIDTH(`SWG_SI_WIDTH)) u_pin_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in({panel_open_key, panel_close_key, bypass_signal_input, trip_acknowledge_input,
               external_open_request, external_close_request, open_interlock, close_interlock,
               aux_open_contact}),
    .level(pin_level),
    .rise(pin_rise)
  );

  // trip manager decode
  // OR of slots
  wire trip_raw = |(protection_trip & trip_slot_assigned);
  wire trip_clear_ok = ~trip_raw & (operator_ack | pin_rise[`SWG_SI_ACK] |
                       ~trip_latch_enable | ~|trip_slot_assigned);
  wire [15:0] next_hold = trip_raw ? trip_hold_cycles :
                          (hold_cnt != 16'h0000) ? hold_cnt - 16'h0001 : 16'h0000;
  wire next_latched = (trip_raw & trip_latch_enable) | (trip_latched & ~trip_clear_ok);
  wire next_trip = trip_raw | (next_hold != 16'h0000) | next_latched;

  // trip manager state; only this path reaches the trip coil
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hold_cnt <= 16'h0000;
      trip_latched <= 1'b0;
      trip_prev <= 1'b0;
      switchgear_trip <= 1'b0;
    end else begin
      hold_cnt <= next_hold;
      trip_latched <= next_latched;
      trip_prev <= switchgear_trip;
      switchgear_trip <= next_trip & ~protection_open_block;
    end
  end

  // authority, interlock and bypass decode
  // authority gating
  wire local_ok = (switching_authority == AUTH_LOCAL) ||
                  (switching_authority == AUTH_LOCAL_REMOTE);
  wire remote_ok = (switching_authority == AUTH_REMOTE) ||
                   (switching_authority == AUTH_LOCAL_REMOTE);
  wire bypass_on = (interlock_bypass_mode == BYPASS_PERMANENT) | bypass_run |
                   pin_level[`SWG_SI_BYPASS];
  wire close_locked = |pin_level[`SWG_SI_ILK_CLOSE +: `SWG_NUM_INTERLOCKS] & ~bypass_on;
  wire open_locked = |pin_level[`SWG_SI_ILK_OPEN +: `SWG_NUM_INTERLOCKS] & ~bypass_on;

  // request sources
  // panel close acts once per press
  wire panel_close = pin_rise[`SWG_SI_PANEL_CLOSE] & local_ok;
  wire panel_open = pin_rise[`SWG_SI_PANEL_OPEN] & local_ok;
  // close on edge, open on level
  wire ext_close = pin_rise[`SWG_SI_EXT_CLOSE] & remote_ok;
  wire ext_open = pin_level[`SWG_SI_EXT_OPEN] & remote_ok;
  wire op_req = panel_open | (scada_open_cmd & remote_ok) | ext_open;
  wire cl_req = panel_close | (scada_close_cmd & remote_ok) | ext_close;
  // protection open and reclose skip interlocks
  wire prot_open = switchgear_trip & ~trip_prev;
  wire open_want = (op_req & ~open_locked) | prot_open;
  wire close_want = (cl_req & ~close_locked) | auto_reclose_unit;
  wire ctl_idle = (ctl_state == CTL_IDLE);
  // position derivation from the single open-side contact
  // live value, so a held open level does not re-issue after the move ends
  // position encoding
  wire [1:0] derived_pos = ~aux_open_wired ? `SWG_POS_DISTURBED :
                           ~ctl_idle ? `SWG_POS_INDETERM :
                           disturbed ? `SWG_POS_DISTURBED :
                           pin_level[`SWG_SI_AUX] ? `SWG_POS_OPEN : `SWG_POS_CLOSED;
  wire [1:0] next_pos = position_override_enable ? position_override_value : derived_pos;
  wire issue_open = ctl_idle & open_want & (next_pos != `SWG_POS_OPEN);
  wire issue_close = ctl_idle & ~op_req & ~prot_open & close_want &
                     (next_pos != `SWG_POS_CLOSED);
  wire issue_any = issue_open | issue_close;
  wire any_req = op_req | cl_req | auto_reclose_unit;

  // move supervision decode
  wire [23:0] move_limit = target_open ? move_open_cycles : move_close_cycles;
  wire end_reached = (target_open == pin_level[`SWG_SI_AUX]);
  wire move_expire = ~ctl_idle & ~end_reached & (move_cnt >= move_limit);

  // bypass window; single mode ends on the first command or timeout
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bypass_run <= 1'b0;
      bypass_cnt <= 24'h000000;
      interlock_bypass_active <= 1'b0;
    end else begin
      interlock_bypass_active <= bypass_on;
      if (bypass_arm && (interlock_bypass_mode == BYPASS_SINGLE ||
                         interlock_bypass_mode == BYPASS_TIMED)) begin
        bypass_run <= 1'b1;
        bypass_cnt <= interlock_bypass_timeout;
      end else if (bypass_run) begin
        bypass_cnt <= bypass_cnt - 24'h000001;
        if (bypass_cnt == 24'h000000 || interlock_bypass_mode == BYPASS_OFF ||
            (interlock_bypass_mode == BYPASS_SINGLE && issue_any)) begin
          bypass_run <= 1'b0;
        end
      end
    end
  end

  // command sequencer; one operation in flight at a time
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl_state <= CTL_IDLE;
      target_open <= 1'b0;
      move_cnt <= 24'h000000;
      disturbed <= 1'b0;
      close_command <= 1'b0;
      open_command <= 1'b0;
      command_rejected <= 1'b0;
      command_busy <= 1'b0;
    end else begin
      close_command <= issue_close;
      open_command <= issue_open;
      command_rejected <= any_req & ~issue_any;
      command_busy <= issue_any | (~ctl_idle & ~end_reached & ~move_expire); // next state
      case (ctl_state)
        CTL_IDLE: begin
          if (issue_any) begin
            ctl_state <= CTL_MOVING;
            target_open <= issue_open;
            move_cnt <= 24'h000000;
            disturbed <= 1'b0;
          end
        end
        CTL_MOVING: begin
          if (end_reached) begin
            ctl_state <= CTL_IDLE;
          end else if (move_expire) begin
            ctl_state <= CTL_IDLE;
            disturbed <= 1'b1;
          end else begin
            move_cnt <= move_cnt + 24'h000001;
          end
        end
        default: ctl_state <= CTL_IDLE;
      endcase
    end
  end

  // registered position; overridden flag drives the display marker
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      breaker_position <= `SWG_POS_INDETERM;
      position_overridden <= 1'b0;
    end else begin
      breaker_position <= next_pos;
      position_overridden <= position_override_enable;
    end
  end

  // operation count and slow alarm; set beats clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      operation_counter <= 16'h0000;
      operations_alarm <= 1'b0;
      slow_operation_alarm <= 1'b0;
    end else begin
      if (issue_any && operation_counter != 16'hFFFF) begin
        operation_counter <= operation_counter + 16'h0001;
      end else if (stats_clear) begin
        operation_counter <= 16'h0000;
      end
      operations_alarm <= operation_counter > operations_limit;
      slow_operation_alarm <= move_expire | (slow_operation_alarm & ~stats_clear);
    end
  end

  // per phase sums of interrupted current
  genvar ph;
  generate
    for (ph = 0; ph < `SWG_NUM_PHASES; ph++) begin : g_phase
      wire [32:0] sum_next = {1'b0, phase_current_accumulator[ph]} + 33'(phase_current[ph]);
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          phase_current_accumulator[ph] <= 32'h00000000;
          phase_current_alarm[ph] <= 1'b0;
        end else if (issue_open) begin
          phase_current_accumulator[ph] <= sum_next[32] ? 32'hFFFFFFFF : sum_next[31:0];
        end else if (stats_clear) begin
          phase_current_accumulator[ph] <= 32'h00000000;
        end else begin
          phase_current_alarm[ph] <= phase_current_accumulator[ph] > current_sum_threshold;
        end
      end
    end
  endgenerate

  // largest phase current drives rate and wear
  wire [15:0] max01 = (phase_current[0] > phase_current[1]) ? phase_current[0] : phase_current[1];
  wire [15:0] wear_i = (max01 > phase_current[2]) ? max01 : phase_current[2];
  wire [32:0] hour_next = {1'b0, hour_sum} + 33'(wear_i);

  // hourly window; the sum restarts each hour
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hour_cnt <= 40'h0000000000;
      hour_sum <= 32'h00000000;
      current_sum_alarm <= 1'b0;
      hourly_current_sum_alarm <= 1'b0;
    end else begin
      current_sum_alarm <= |phase_current_alarm;
      if (hour_cnt >= HOUR_CYCLES - 40'h0000000001) begin
        hour_cnt <= 40'h0000000000;
        hour_sum <= 32'h00000000;
      end else begin
        hour_cnt <= hour_cnt + 40'h0000000001;
        if (issue_open) begin
          hour_sum <= hour_next[32] ? 32'hFFFFFFFF : hour_next[31:0];
        end
      end
      hourly_current_sum_alarm <= hour_sum > hourly_sum_threshold;
    end
  end

  // wear curve segment search; last used point counts as zero operations
  logic [3:0] last_pt;
  logic seg_found;
  logic [15:0] seg_lo_c;
  logic [15:0] seg_lo_o;
  logic [15:0] seg_hi_o;
  logic [15:0] seg_span;
  always_comb begin
    last_pt = (curve_points_used == 4'h0) ? 4'h0 :
              (curve_points_used > 4'hA) ? 4'h9 : curve_points_used - 4'h1;
    seg_found = 1'b0;
    seg_lo_c = curve_current[0];
    seg_lo_o = (last_pt == 4'h0) ? 16'h0000 : curve_allowed_ops[0];
    seg_hi_o = seg_lo_o;
    seg_span = 16'h0000;
    for (int k = 1; k < `SWG_CURVE_POINTS; k++) begin
      if (!seg_found && wear_i > curve_current[0] && 4'(k) <= last_pt &&
          wear_i <= curve_current[k]) begin
        seg_found = 1'b1;
        seg_lo_c = curve_current[k-1];
        seg_lo_o = curve_allowed_ops[k-1];
        seg_hi_o = (4'(k) == last_pt) ? 16'h0000 : curve_allowed_ops[k];
        seg_span = curve_current[k] - curve_current[k-1];
      end
    end
  end
  wire beyond = wear_i > curve_current[last_pt];
  wire [15:0] ops_drop = (seg_lo_o > seg_hi_o) ? seg_lo_o - seg_hi_o : 16'h0000;
  wire [31:0] interp_num = ops_drop * (wear_i - seg_lo_c);
  wire [15:0] direct_ops = beyond ? 16'h0000 : seg_lo_o;
  wire [15:0] interp_ops = wear_lo_ops - div_q[15:0];
  wire [32:0] div_trial = {div_r[31:0], div_q[31]};
  wire div_fit = div_trial >= {1'b0, div_d};
  wire [38:0] pct_full = 39'(wear_acc) * 39'h64;
  wire [18:0] pct_raw = pct_full[38:`SWG_WEAR_FRAC_BITS];
  wire [32:0] wear_next = {1'b0, wear_acc} + {1'b0, div_q};

  // wear engine: interpolate allowed ops, then add one over that to life used
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wear_state <= WEAR_IDLE;
      wear_pend <= 1'b0;
      wear_lo_ops <= 16'h0000;
      wear_acc <= 32'h00000000;
      div_q <= 32'h00000000;
      div_r <= 33'h000000000;
      div_d <= 32'h00000000;
      div_cnt <= 6'h00;
      open_capacity_percent <= 8'h00;
      wear_curve_alarm <= 1'b0;
    end else begin
      if (issue_open) begin
        wear_pend <= 1'b1;
      end
      if (div_cnt != 6'h00) begin
        div_cnt <= div_cnt - 6'h01;
        div_r <= div_fit ? div_trial - {1'b0, div_d} : div_trial;
        div_q <= {div_q[30:0], div_fit};
      end
      case (wear_state)
        WEAR_IDLE: begin
          if (wear_pend && !issue_open) begin
            wear_pend <= 1'b0;
            wear_lo_ops <= seg_lo_o;
            div_r <= 33'h000000000;
            div_cnt <= `SWG_DIV_STEPS;
            if (seg_found && !beyond && seg_span != 16'h0000) begin
              div_q <= interp_num;
              div_d <= 32'(seg_span);
              wear_state <= WEAR_INTERP;
            end else if (direct_ops == 16'h0000) begin
              div_q <= `SWG_WEAR_ONE;
              div_cnt <= 6'h00;
              wear_state <= WEAR_ADD;
            end else begin
              div_q <= `SWG_WEAR_ONE;
              div_d <= 32'(direct_ops);
              wear_state <= WEAR_RECIP;
            end
          end
        end
        WEAR_INTERP: begin
          if (div_cnt == 6'h00) begin
            div_r <= 33'h000000000;
            if (interp_ops == 16'h0000) begin
              div_q <= `SWG_WEAR_ONE;
              wear_state <= WEAR_ADD;
            end else begin
              div_q <= `SWG_WEAR_ONE;
              div_d <= 32'(interp_ops);
              div_cnt <= `SWG_DIV_STEPS;
              wear_state <= WEAR_RECIP;
            end
          end
        end
        WEAR_RECIP: begin
          if (div_cnt == 6'h00) begin
            wear_state <= WEAR_ADD;
          end
        end
        WEAR_ADD: begin
          wear_acc <= wear_next[32] ? 32'hFFFFFFFF : wear_next[31:0];
          wear_state <= WEAR_IDLE;
        end
        default: wear_state <= WEAR_IDLE;
      endcase
      if (stats_clear && wear_state != WEAR_ADD) begin
        wear_acc <= 32'h00000000;
      end
      open_capacity_percent <= (pct_raw >= 19'h00064) ? `SWG_PERCENT_FULL : pct_raw[7:0];
      wear_curve_alarm <= pct_raw >= 19'h00064;
    end
  end
endmodule
`default_nettype wire

/* File: inc/swg_defs.svh */
`ifndef SWG_DEFS_SVH
`define SWG_DEFS_SVH

// encoded breaker position
`define SWG_POS_INDETERM 2'h0
`define SWG_POS_OPEN 2'h1
`define SWG_POS_CLOSED 2'h2
`define SWG_POS_DISTURBED 2'h3

// sizes
`define SWG_TRIP_SLOTS 8
`define SWG_NUM_INTERLOCKS 3
`define SWG_NUM_PHASES 3
`define SWG_CURVE_POINTS 10
`define SWG_CURVE_IDX_W 4

// positions inside the synchronised pin vector
`define SWG_SI_AUX 0
`define SWG_SI_ILK_CLOSE 1
`define SWG_SI_ILK_OPEN 4
`define SWG_SI_EXT_CLOSE 7
`define SWG_SI_EXT_OPEN 8
`define SWG_SI_ACK 9
`define SWG_SI_BYPASS 10
`define SWG_SI_PANEL_CLOSE 11
`define SWG_SI_PANEL_OPEN 12
`define SWG_SI_WIDTH 13

// wear life fixed point: one full life is 2^20
`define SWG_WEAR_FRAC_BITS 20
`define SWG_WEAR_ONE 32'h0010_0000
`define SWG_PERCENT_FULL 8'h64
`define SWG_DIV_STEPS 6'h20

// hourly window
`define SWG_HOUR_S 3600
`define SWG_NS_PER_S 64'd1000000000
`define SWG_CLK_PERIOD_NS 10

`endif

/* File: inc/swg_pkg.sv */
package swg_pkg;
  typedef enum logic [1:0] {AUTH_NONE, AUTH_LOCAL, AUTH_REMOTE, AUTH_LOCAL_REMOTE} authority_e;
  typedef enum logic [1:0] {BYPASS_OFF, BYPASS_SINGLE, BYPASS_PERMANENT, BYPASS_TIMED} bypass_e;
  typedef enum logic {CTL_IDLE, CTL_MOVING} ctl_state_e;
  typedef enum logic [1:0] {WEAR_IDLE, WEAR_INTERP, WEAR_RECIP, WEAR_ADD} wear_state_e;
endpackage
